// ==== analog_side_model.sv ====
// Model of the current source, charged node and comparator
module analog_side_model #(
   parameter logic [7:0] TRIP = 8'h0A
) (
   // Controls from the unit
   input  wire logic       clk,
   input  wire logic       current_source_enable,
   input  wire logic       node_discharge,
   // Node and comparator
   output logic      [7:0] node_level,
   output logic            comparator_trip
);
   timeunit 1ns;
   timeprecision 1ns;
   // Bare node with no trace load, as on an unused converter channel
   initial node_level = 8'h00;
   // One step a cycle; grounding wins over charging
   always @(posedge clk) begin
      if (node_discharge) begin
         node_level <= 8'h00;
      end else if (current_source_enable && node_level != 8'hFF) begin
         node_level <= node_level + 8'h01;
      end
   end
   assign comparator_trip = (node_level >= TRIP);
endmodule

// ==== charge_time_chk.sv ====
// Port checker of the charge time unit
module charge_time_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Register bus
   input wire logic [3:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // Power and analog side
   input wire logic        sleep_mode,
   input wire logic        idle_mode,
   input wire logic        comparator_trip,
   input wire logic        delay_trigger_input,
   input wire logic        current_source_enable,
   input wire logic        node_discharge,
   input wire logic        delay_pulse_output
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] hi_q, lo_q, od_q;
   logic       en, tg, sel, meas;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Shadow copies of the control registers
   always_ff @(posedge clk) begin
      if (reset) begin
         {hi_q, lo_q, od_q} <= 24'h000000;
      end else if (write && !waitrequest) begin
         if (address == 4'h0) hi_q <= writedata[7:0];
         if (address == 4'h4) lo_q <= writedata[7:0];
         if (address == 4'h8) od_q <= writedata[7:0];
      end
   end
   assign en = hi_q[7];
   assign tg = hi_q[4] && en;
   assign sel = od_q[0] ? delay_trigger_input : comparator_trip;
   assign meas = en && lo_q[0] && !lo_q[1] && !sleep_mode
                 && !(idle_mode && hi_q[5]);
   sequence s_quiet;
      (!sel && !sleep_mode && !idle_mode) [*3];
   endsequence
   property p_reset_clear;
      $fell(reset) |-> !current_source_enable && !node_discharge
         && !delay_pulse_output && waitrequest;
   endproperty
   property p_wait_one;
      (read || write) && waitrequest |=> !waitrequest;
   endproperty
   property p_meas;
      !hi_q[4] |=> current_source_enable == $past(meas);
   endproperty
   property p_disc;
      node_discharge == $past(en && hi_q[1]);
   endproperty
   property p_time_generation_enable;
      !tg |=> !delay_pulse_output;
   endproperty
   property p_rise;
      s_quiet ##0 (tg && $rose(lo_q[0])) |=> delay_pulse_output;
   endproperty
   property p_hold;
      s_quiet ##0 (tg && lo_q[0] && delay_pulse_output) |=> delay_pulse_output;
   endproperty
   property p_fall;
      tg && delay_pulse_output && $rose(sel) |-> ##[1:3] !delay_pulse_output;
   endproperty
   property p_after;
      tg && $fell(delay_pulse_output) |=> !current_source_enable;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("outputs not cleared by reset");
   a_wait_one: assert property (p_wait_one)
      else $error("bus access not answered in one cycle");
   a_meas: assert property (p_meas)
      else $error("current source state wrong");
   a_disc: assert property (p_disc)
      else $error("discharge state wrong");
   a_time_generation_enable: assert property (p_time_generation_enable)
      else $error("pulse outside delay mode");
   a_rise: assert property (p_rise)
      else $error("pulse did not start");
   a_hold: assert property (p_hold)
      else $error("pulse ended without its source");
   a_fall: assert property (p_fall)
      else $error("pulse did not end after trip");
   a_after: assert property (p_after)
      else $error("source still on after pulse");
   c_pulse: cover property (tg && $fell(delay_pulse_output));
   c_sleep: cover property (sleep_mode && en && lo_q[0]);
   c_meas: cover property (!tg && $fell(current_source_enable));
endmodule
bind charge_time_unit charge_time_chk u_charge_time_chk (.clk, .reset,
   .address, .read, .write, .writedata, .readdata, .waitrequest,
   .sleep_mode, .idle_mode, .comparator_trip, .delay_trigger_input,
   .current_source_enable, .node_discharge, .delay_pulse_output);

// ==== charge_time_pkg.sv ====
// Register map, field positions and reset values of the charge time unit
package charge_time_pkg;

   // Register byte offsets
   localparam logic [3:0] CONTROL_HIGH_OFS   = 4'h0;
   localparam logic [3:0] CONTROL_LOW_OFS    = 4'h4;
   localparam logic [3:0] OPEN_DRAIN_CTL_OFS = 4'h8;
   localparam logic [3:0] STATUS_OFS         = 4'hC;

   // Fields of unit_control_high
   localparam int UNIT_ENABLE_BIT    = 7;
   localparam int STOP_IN_IDLE_BIT   = 5;
   localparam int TIME_GEN_BIT       = 4;
   localparam int NODE_DISCHARGE_BIT = 1;

   // Fields of unit_control_low
   localparam int FIRST_EDGE_BIT  = 0;
   localparam int SECOND_EDGE_BIT = 1;

   // Field of open_drain_control_three
   localparam int DELAY_SOURCE_BIT = 0;

   // Fields of the status register
   localparam int STAT_SOURCE_ON_BIT  = 0;
   localparam int STAT_DISCHARGE_BIT  = 1;
   localparam int STAT_PULSE_BIT      = 2;
   localparam int STAT_TRIPPED_BIT    = 3;
   localparam int STAT_SOURCE_OFF_BIT = 4;

   // Reset values
   localparam logic [7:0] CONTROL_HIGH_RST   = 8'h00;
   localparam logic [7:0] CONTROL_LOW_RST    = 8'h00;
   localparam logic [7:0] OPEN_DRAIN_CTL_RST = 8'h00;

   // Implemented bits of each control register
   localparam logic [7:0] CONTROL_HIGH_MASK   = 8'hB2;
   localparam logic [7:0] CONTROL_LOW_MASK    = 8'h03;
   localparam logic [7:0] OPEN_DRAIN_CTL_MASK = 8'h01;

endpackage

// ==== charge_time_unit.sv ====
// Charge time unit: register slave, current source and discharge control

module charge_time_unit (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Avalon-MM slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Power manager
   input  wire logic        sleep_mode,
   input  wire logic        idle_mode,
   // Analog and pin side
   input  wire logic        comparator_trip,
   input  wire logic        delay_trigger_input,
   output logic             current_source_enable,
   output logic             node_discharge,
   output logic             delay_pulse_output
);

   // Register state
   logic [7:0]  unit_control_high_q;
   logic [7:0]  unit_control_high_d;
   logic [7:0]  unit_control_low_q;
   logic [7:0]  unit_control_low_d;
   logic [7:0]  open_drain_control_three_q;
   logic [7:0]  open_drain_control_three_d;
   logic        ack_q;
   logic        ack_d;
   logic [31:0] readdata_q;
   logic [31:0] readdata_d;

   // Output state
   logic        source_q;
   logic        source_d;
   logic        discharge_q;
   logic        discharge_d;

   // Decoded controls
   logic        unit_enable;
   logic        stop_in_idle;
   logic        time_generation_enable;
   logic        node_discharge_enable;
   logic        first_edge_status;
   logic        second_edge_status;
   logic        delay_source_select;
   logic        source_blocked;
   logic        write_take;
   logic [7:0]  status_byte;

   delay_pulse_if pulse_bus ();

   delay_pulse_gen pulse_gen (
      .clk                 (clk),
      .reset               (reset),
      .comparator_trip     (comparator_trip),
      .delay_trigger_input (delay_trigger_input),
      .ctl                 (pulse_bus.generator)
   );

   always_comb begin
      unit_enable = unit_control_high_q[charge_time_pkg::UNIT_ENABLE_BIT];
      stop_in_idle =
         unit_control_high_q[charge_time_pkg::STOP_IN_IDLE_BIT];
      time_generation_enable =
         unit_control_high_q[charge_time_pkg::TIME_GEN_BIT];
      node_discharge_enable =
         unit_control_high_q[charge_time_pkg::NODE_DISCHARGE_BIT];
      first_edge_status =
         unit_control_low_q[charge_time_pkg::FIRST_EDGE_BIT];
      second_edge_status =
         unit_control_low_q[charge_time_pkg::SECOND_EDGE_BIT];
      delay_source_select =
         open_drain_control_three_q[charge_time_pkg::DELAY_SOURCE_BIT];
   end

   // Sleep always starves the source; idle only when asked to stop
   assign source_blocked = sleep_mode
                         | (idle_mode & stop_in_idle);

   // Delay mode is armed from the first edge bit only when enabled
   assign pulse_bus.arm = unit_enable & time_generation_enable
                        & first_edge_status;
   assign pulse_bus.source_select = delay_source_select;

   // Current source and discharge switch
   always_comb begin
      if (time_generation_enable) begin
         // Charge the delay capacitor until the trip is seen
         source_d = pulse_bus.arm & ~pulse_bus.tripped;
      end else begin
         // Second edge closes the measured interval
         source_d = unit_enable & first_edge_status
                  & ~second_edge_status;
      end
      source_d    = source_d & ~source_blocked;
      discharge_d = unit_enable & node_discharge_enable;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         source_q    <= 1'h0;
         discharge_q <= 1'h0;
      end else begin
         source_q    <= source_d;
         discharge_q <= discharge_d;
      end
   end

   assign current_source_enable = source_q;
   assign node_discharge        = discharge_q;
   // Pulse rises when software arms delay mode and falls on the selected trip source or on disarm
   assign delay_pulse_output    = pulse_bus.pulse;

   always_comb begin
      status_byte = 8'h00;
      status_byte[charge_time_pkg::STAT_SOURCE_ON_BIT]  = source_q;
      status_byte[charge_time_pkg::STAT_DISCHARGE_BIT]  = discharge_q;
      status_byte[charge_time_pkg::STAT_PULSE_BIT]      = pulse_bus.pulse;
      status_byte[charge_time_pkg::STAT_TRIPPED_BIT]    =
         pulse_bus.tripped;
      status_byte[charge_time_pkg::STAT_SOURCE_OFF_BIT] = source_blocked;
   end

   // Bus slave: every access waits exactly one cycle, then completes
   assign waitrequest = ~ack_q;
   assign write_take  = write & ack_q;

   always_comb begin
      ack_d      = (read | write) & ~ack_q;
      readdata_d = readdata_q;
      if (read & ~ack_q) begin
         unique case (address)
            charge_time_pkg::CONTROL_HIGH_OFS:
               readdata_d = {24'h000000, unit_control_high_q};
            charge_time_pkg::CONTROL_LOW_OFS:
               readdata_d = {24'h000000, unit_control_low_q};
            charge_time_pkg::OPEN_DRAIN_CTL_OFS:
               readdata_d = {24'h000000, open_drain_control_three_q};
            charge_time_pkg::STATUS_OFS:
               readdata_d = {24'h000000, status_byte};
            default:
               readdata_d = 32'h00000000;
         endcase
      end
   end

   always_comb begin
      unit_control_high_d        = unit_control_high_q;
      unit_control_low_d         = unit_control_low_q;
      open_drain_control_three_d = open_drain_control_three_q;
      if (write_take) begin
         unique case (address)
            charge_time_pkg::CONTROL_HIGH_OFS:
               unit_control_high_d = writedata[7:0]
                  & charge_time_pkg::CONTROL_HIGH_MASK;
            charge_time_pkg::CONTROL_LOW_OFS:
               unit_control_low_d = writedata[7:0]
                  & charge_time_pkg::CONTROL_LOW_MASK;
            charge_time_pkg::OPEN_DRAIN_CTL_OFS:
               open_drain_control_three_d = writedata[7:0]
                  & charge_time_pkg::OPEN_DRAIN_CTL_MASK;
            default: begin
               // Status and unmapped offsets ignore writes
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         unit_control_high_q        <=
            charge_time_pkg::CONTROL_HIGH_RST;
         unit_control_low_q         <= charge_time_pkg::CONTROL_LOW_RST;
         open_drain_control_three_q <=
            charge_time_pkg::OPEN_DRAIN_CTL_RST;
         ack_q                      <= 1'h0;
         readdata_q                 <= 32'h00000000;
      end else begin
         unit_control_high_q        <= unit_control_high_d;
         unit_control_low_q         <= unit_control_low_d;
         open_drain_control_three_q <= open_drain_control_three_d;
         ack_q                      <= ack_d;
         readdata_q                 <= readdata_d;
      end
   end

   assign readdata = readdata_q;

endmodule

// ==== delay_pulse_gen.sv ====
// Delay pulse generator: synchronises trip sources and shapes the pulse
module delay_pulse_gen (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // Analog and pin side
   input  wire logic         comparator_trip,
   input  wire logic         delay_trigger_input,
   // Control side
   delay_pulse_if.generator  ctl
);

   logic [1:0] comp_sync_q;
   logic [1:0] comp_sync_d;
   logic [1:0] trig_sync_q;
   logic [1:0] trig_sync_d;
   logic       tripped_q;
   logic       tripped_d;
   logic       pulse_q;
   logic       pulse_d;
   logic       trip_event;

   always_comb begin
      comp_sync_d = {comp_sync_q[0], comparator_trip};
      trig_sync_d = {trig_sync_q[0], delay_trigger_input};
      // Comparator ends the delay unless the pin is selected
      trip_event  = ctl.source_select ? trig_sync_q[1]
                                      : comp_sync_q[1];
      // Trip stays caught until arm drops
      tripped_d   = ctl.arm & (tripped_q | trip_event);
      pulse_d     = ctl.arm & ~tripped_d;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         comp_sync_q <= 2'h0;
         trig_sync_q <= 2'h0;
         tripped_q   <= 1'h0;
         pulse_q     <= 1'h0;
      end else begin
         comp_sync_q <= comp_sync_d;
         trig_sync_q <= trig_sync_d;
         tripped_q   <= tripped_d;
         pulse_q     <= pulse_d;
      end
   end

   assign ctl.tripped = tripped_q;
   assign ctl.pulse   = pulse_q;

endmodule

// ==== delay_pulse_if.sv ====
// Signals between the control registers and the delay pulse generator
interface delay_pulse_if;
   logic arm;
   logic source_select;
   logic tripped;
   logic pulse;

   modport control (output arm, output source_select,
                    input tripped, input pulse);
   modport generator (input arm, input source_select,
                      output tripped, output pulse);
endinterface

// ==== test_charge_time_unit.sv ====
// Testbench of the charge time unit
module test_charge_time_unit;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] TRIP = 8'h0A;
   localparam int         K    = 20;
   logic        clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
   logic        sleep_mode = 1'b0, idle_mode = 1'b0;
   logic        delay_trigger_input = 1'b0;
   logic [3:0]  address = 4'h0;
   logic [31:0] writedata = 32'h00000000;
   logic [31:0] readdata, rd;
   logic [7:0]  node_level;
   logic        waitrequest, comparator_trip, current_source_enable;
   logic        node_discharge, delay_pulse_output;
   int          n_mismatch = 0, total_checks = 0, cycles = 0, c;
   always #50 clk = ~clk;
   charge_time_unit u_charge_time_unit (.clk, .reset, .address, .read,
      .write, .writedata, .readdata, .waitrequest, .sleep_mode, .idle_mode,
      .comparator_trip, .delay_trigger_input, .current_source_enable,
      .node_discharge, .delay_pulse_output);
   analog_side_model #(.TRIP(TRIP)) u_analog_side_model (.clk,
      .current_source_enable, .node_discharge, .node_level,
      .comparator_trip);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      address <= a;
      writedata <= {24'h000000, d};
      write <= wr;
      read <= !wr;
      do @(posedge clk); while (waitrequest !== 1'b0 && cycles < 3000);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   // Counts pulse-high cycles over a window
   task automatic width(input int n);
      c = 0;
      repeat (n) begin
         @(negedge clk);
         if (delay_pulse_output === 1'b1) c++;
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, 4'(4 * i), 8'h00);
         chk(rd, 0);
      end
      bus(1'b1, 4'h0, 8'hFF);
      bus(1'b0, 4'h0, 8'h00);
      chk(rd, {24'h000000, charge_time_pkg::CONTROL_HIGH_MASK});
      bus(1'b0, 4'h2, 8'h00);
      chk(rd, 0);
      // Charge for a fixed time, then by two edges
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, 4'h0, 8'h82);
         // Switch follows the register one edge after the write lands
         repeat (2) @(negedge clk);
         chk(node_discharge, 1);
         bus(1'b1, 4'h0, 8'h80);
         bus(1'b1, 4'h4, 8'h01);
         repeat (K) @(posedge clk);
         bus(1'b1, 4'h4, m ? 8'h03 : 8'h00);
         repeat (3) @(posedge clk);
         chk(node_level, K + 3);
      end
      bus(1'b1, 4'h4, 8'h01);
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, 4'h0, i == 2 ? 8'hA0 : 8'h80);
         sleep_mode <= (i == 0);
         idle_mode <= (i != 0);
         repeat (2) @(posedge clk);
         chk(current_source_enable, i == 1);
         sleep_mode <= 1'b0;
         idle_mode <= 1'b0;
      end
      // Comparator ends the pulse, then the pin does
      bus(1'b1, 4'h4, 8'h00);
      bus(1'b1, 4'h0, 8'h82);
      bus(1'b1, 4'h8, 8'h00);
      bus(1'b1, 4'h0, 8'h90);
      bus(1'b1, 4'h4, 8'h01);
      width(30);
      chk(c, TRIP + 3);
      chk(current_source_enable, 0);
      bus(1'b0, charge_time_pkg::STATUS_OFS, 8'h00);
      chk(rd, 32'h00000008);
      bus(1'b1, 4'h4, 8'h00);
      bus(1'b1, 4'h8, 8'h01);
      bus(1'b1, 4'h4, 8'h01);
      @(posedge clk);
      width(20);
      chk(c, 20);
      @(posedge clk);
      delay_trigger_input <= 1'b1;
      width(10);
      chk(c, 3);
      bus(1'b1, 4'h0, 8'h80);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      chk(current_source_enable, 0);
      bus(1'b0, 4'h4, 8'h00);
      chk(rd, 0);
      summarize();
   end
endmodule
